// >>> hw/reset_mode_latch_ext_irq.sv
// Reset release, boot mode latch and external interrupt request lines.
// Assumes pins are synchronous to ref_clk and the core supplies config.
// Functional notes
// - Reset pin low holds chip reset and clears the phase generator.
// - Reset release passes two sync flops before reset ends.
// - Release to run takes a fixed count, so devices start lock-step.
// - At release the four mode pins are latched into the mode register.
// - After reset each pin is an active-low maskable level or edge request.
// - Each request pin is synchronised before the interrupt logic uses it.
// - A request while in wait state wakes the processor from wait.
// - A request while in stop standby wakes the processor from stop.
`timescale 1ns/100ps
module reset_mode_latch_ext_irq
  import rstmode_pkg::*;
#(
  parameter int NUM_LINES = MODE_BITS
)
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // Device pins
  input  wire logic                 chip_reset_n,
  input  wire logic [NUM_LINES-1:0] mode_select_n,
  // Core configuration and handshake
  input  wire irq_cfg_s             irq_cfg,
  input  wire logic [NUM_LINES-1:0] irq_ack,
  input  wire logic                 core_in_wait,
  input  wire logic                 core_in_stop,
  // Core outputs
  output logic                      core_reset,
  output logic                      clock_phase,
  output logic [NUM_LINES-1:0]      operating_mode_register,
  output logic [NUM_LINES-1:0]      irq_req,
  output logic                      wake_from_wait,
  output logic                      wake_from_stop
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_LINES != MODE_BITS)
  begin : g_bad_lines
    $error("NUM_LINES must equal MODE_BITS");
  end

  top_state_s           st_r;
  top_state_s           st_nxt;
  logic [NUM_LINES-1:0] line_level;
  logic                 run;

  assign run = (st_r.state == RST_RUN);

  // ----------------------------------------------------------------
  // Request lines, shared with the mode pins
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_LINES; i++)
  begin : g_line
    irq_line_sync u_line (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .pin_n      (mode_select_n[i]),
      .run        (run),
      .edge_mode  (irq_cfg.edge_mode[i]),
      .enable     (irq_cfg.enable[i]),
      .ack        (irq_ack[i]),
      .level_sync (line_level[i]),
      .request    (irq_req[i])
    );
  end

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.rel_1 = chip_reset_n;
    st_nxt.rel_2 = st_r.rel_1;
    unique case (st_r.state)
      RST_HELD:
      begin
        st_nxt.phase = PHASE_RESET;
        if (st_r.rel_2 && chip_reset_n)
        begin
          st_nxt.state = RST_RUN;
          // Synced pin levels, index order gives bit order
          st_nxt.mode  = line_level;
        end
      end
      RST_RUN:
      begin
        st_nxt.phase = ~st_r.phase;
      end
    endcase
    // Assertion acts at once and cancels any release in flight
    if (!chip_reset_n)
    begin
      st_nxt.state = RST_HELD;
      st_nxt.rel_1 = 1'b0;
      st_nxt.rel_2 = 1'b0;
      st_nxt.phase = PHASE_RESET;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_r <= '{state: RST_HELD, rel_1: 1'b0, rel_2: 1'b0,
                phase: PHASE_RESET, mode: MODE_RESET};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign core_reset              = ~run;
  assign clock_phase             = st_r.phase;
  assign operating_mode_register = st_r.mode;
  // Masked lines do not wake the core; enable them before wait or stop
  assign wake_from_wait          = core_in_wait & (|irq_req);
  assign wake_from_stop          = core_in_stop & (|irq_req);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reset_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !chip_reset_n |=> core_reset && !clock_phase)
    else $error("reset pin low did not hold reset");

  release_early_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(chip_reset_n) ##1 chip_reset_n [*2] |-> core_reset)
    else $error("reset left before release was synchronised");

  release_lat_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(chip_reset_n) ##1 chip_reset_n [*2] |=> !core_reset && !clock_phase)
    else $error("release latency not fixed");

  phase_run_a: assert property (@(posedge ref_clk) disable iff (reset)
    !core_reset && $past(!core_reset) |-> clock_phase != $past(clock_phase))
    else $error("phase generator stalled while running");

  mode_cap_a: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(core_reset) |-> operating_mode_register == $past(line_level))
    else $error("mode not latched at release");

  mode_bit0_a: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(core_reset) |-> operating_mode_register[0] == $past(line_level[0]))
    else $error("first mode pin not in bit 0");

  mode_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !core_reset && $past(!core_reset) |-> $stable(operating_mode_register))
    else $error("mode register changed while running");

  req_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    core_reset |-> irq_req == '0)
    else $error("request raised during reset");

  wake_wait_a: assert property (@(posedge ref_clk) disable iff (reset)
    core_in_wait && (irq_req != '0) |-> wake_from_wait)
    else $error("request did not wake from wait");

  wake_stop_a: assert property (@(posedge ref_clk) disable iff (reset)
    core_in_stop && (irq_req != '0) |-> wake_from_stop)
    else $error("request did not wake from stop");

  release_c: cover property (@(posedge ref_clk) disable iff (reset)
    $fell(core_reset));

  wait_wake_c: cover property (@(posedge ref_clk) disable iff (reset)
    wake_from_wait);

  stop_wake_c: cover property (@(posedge ref_clk) disable iff (reset)
    wake_from_stop);

  abort_c: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(chip_reset_n) ##1 !chip_reset_n);

endmodule // reset_mode_latch_ext_irq

// >>> common/rstmode_pkg.sv
// Shared constants, modes and carriers for the reset, mode latch and
// external interrupt block. Assumes a single clock domain on ref_clk.
package rstmode_pkg;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int           MODE_BITS       = 4;
  localparam logic [3:0]   MODE_RESET      = 4'h0;
  localparam logic         PHASE_RESET     = 1'b0;
  // Edges from pin release to leaving reset: two sync stages plus state
  localparam int           RELEASE_LATENCY = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {
    RST_HELD,
    RST_RUN
  } rst_state_e;

  // Per-line configuration from the core, applied directly without synchronising
  typedef struct packed {
    logic [MODE_BITS-1:0] edge_mode;
    logic [MODE_BITS-1:0] enable;
  } irq_cfg_s;

  typedef struct packed {
    logic sync_1;
    logic sync_2;
    logic prev;
    logic pend;
  } line_state_s;

  typedef struct packed {
    rst_state_e           state;
    logic                 rel_1;
    logic                 rel_2;
    logic                 phase;
    logic [MODE_BITS-1:0] mode;
  } top_state_s;

endpackage

// >>> hw/irq_line_sync.sv
// One external request line: synchroniser, falling edge catch, request.
// Assumes pin_n is the raw active-low line shared with a mode select input.
`timescale 1ns/100ps
module irq_line_sync
  import rstmode_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Pin side
  input  wire logic pin_n,
  // Core side
  input  wire logic run,
  input  wire logic edge_mode,
  input  wire logic enable,
  input  wire logic ack,
  output logic      level_sync,
  output logic      request
);

  line_state_s st_r;
  line_state_s st_nxt;
  logic        fall;

  assign fall = st_r.prev & ~st_r.sync_2;

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.sync_1 = pin_n;
    st_nxt.sync_2 = st_r.sync_1;
    st_nxt.prev   = st_r.sync_2;
    // Set wins over ack so a fresh edge is never lost
    st_nxt.pend   = fall | (st_r.pend & ~ack & edge_mode);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_r <= '{sync_1: 1'b1, sync_2: 1'b1, prev: 1'b1, pend: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign level_sync = st_r.sync_2;
  // Level mode follows the low pin; edge mode holds until acknowledged
  assign request = run & enable & (edge_mode ? st_r.pend : ~st_r.sync_2);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  edge_catch_a: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(pin_n) ##1 !pin_n [*2] |=> st_r.pend)
    else $error("falling edge not caught after two sync stages");

  set_wins_a: assert property (@(posedge ref_clk) disable iff (reset)
    fall && ack |=> st_r.pend)
    else $error("edge lost when ack met a new edge");

  ack_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    st_r.pend && ack && !fall |=> !st_r.pend)
    else $error("pending edge not cleared by ack");

endmodule // irq_line_sync

// >>> verification/pin_source.sv
// Model of the reset source and the external request line drivers.
// Assumes the bench commands it just after each ref_clk rising edge.
`timescale 1ns/100ps
module pin_source
  import rstmode_pkg::*;
(
  // Clock
  input  wire logic                 ref_clk,
  // Bench commands
  input  wire logic                 run_req,
  input  wire logic [MODE_BITS-1:0] lines_n,
  // Device pins
  output logic                      chip_reset_n,
  output logic [MODE_BITS-1:0]      mode_select_n
);
  // -----------------------------------------------------------------
  // Pin drive
  // -----------------------------------------------------------------
  logic                 run_seen;
  logic [MODE_BITS-1:0] lines_seen;

  // Low from power up until the bench first asks for a run
  initial
  begin
    chip_reset_n  = 1'b0;
    mode_select_n = 4'hF;
    forever
    begin
      // Commands taken on the edge, so the bench write 1 ns later never races
      @(posedge ref_clk);
      run_seen   = run_req;
      lines_seen = lines_n;
      #1;
      chip_reset_n  = run_seen;
      mode_select_n = lines_seen;
    end
  end
endmodule // pin_source

// >>> verification/tb_reset_mode_latch_ext_irq.sv
// Self-checking bench for reset release, mode latch and request lines.
// Assumes NUM_LINES is 4 and the pin model answers a cycle after command.
`timescale 1ns/100ps
module tb_reset_mode_latch_ext_irq
  import rstmode_pkg::*;
;
  logic       ref_clk, reset, run_req, core_in_wait, core_in_stop;
  logic       chip_reset_n, core_reset, clock_phase, wake_from_wait, wake_from_stop;
  logic [3:0] lines_n, irq_ack, mode_select_n, operating_mode_register, irq_req;
  irq_cfg_s   irq_cfg;
  int         failures, num_checks, cycles;

  pin_source src (.ref_clk(ref_clk), .run_req(run_req), .lines_n(lines_n),
    .chip_reset_n(chip_reset_n), .mode_select_n(mode_select_n));

  reset_mode_latch_ext_irq dut (.ref_clk(ref_clk), .reset(reset),
    .chip_reset_n(chip_reset_n), .mode_select_n(mode_select_n), .irq_cfg(irq_cfg),
    .irq_ack(irq_ack), .core_in_wait(core_in_wait), .core_in_stop(core_in_stop),
    .core_reset(core_reset), .clock_phase(clock_phase),
    .operating_mode_register(operating_mode_register), .irq_req(irq_req),
    .wake_from_wait(wake_from_wait), .wake_from_stop(wake_from_stop));

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task t_boot(input logic [3:0] m);
    run_req = 1'b0;
    cyc(2);
    chk("reset held", {3'h0, core_reset}, 4'h1);
    chk("phase reset", {3'h0, clock_phase}, 4'h0);
    lines_n = m;
    run_req = 1'b1;
    cyc(3);
    chk("sync hold", {3'h0, core_reset}, 4'h1);
    // Pins change after capture: the register must not follow them
    lines_n = ~m;
    cyc(1);
    chk("release", {3'h0, core_reset}, 4'h0);
    chk("phase start", {3'h0, clock_phase}, 4'h0);
    chk("mode", operating_mode_register, m);
    cyc(1);
    chk("phase run", {3'h0, clock_phase}, 4'h1);
    cyc(2);
    chk("mode hold", operating_mode_register, m);
    $display("test boot %h done", m);
  endtask

  task t_glitch();
    run_req = 1'b0;
    cyc(2);
    // One and two cycle highs both fall short of a release
    for (int w = 1; w < 3; w++)
    begin
      run_req = 1'b1;
      cyc(w);
      run_req = 1'b0;
      repeat (4)
      begin
        cyc(1);
        chk("glitch", {3'h0, core_reset}, 4'h1);
      end
    end
    $display("test glitch done");
    t_boot(4'h5);
  endtask

  task t_level(input int i);
    logic [3:0] b;
    b = 4'h1 << i;
    irq_cfg = '{edge_mode: 4'h0, enable: 4'hF};
    core_in_wait = ~i[0];
    core_in_stop = i[0];
    lines_n = 4'hF;
    cyc(4);
    lines_n[i] = 1'b0;
    cyc(2);
    chk("level early", irq_req, 4'h0);
    cyc(1);
    chk("level req", irq_req, b);
    chk("wake", {2'h0, wake_from_stop, wake_from_wait}, 4'h1 << i[0]);
    irq_cfg.enable = 4'hF & ~b;
    cyc(1);
    chk("level mask", irq_req, 4'h0);
    irq_cfg.enable = 4'hF;
    lines_n = 4'hF;
    cyc(3);
    chk("level gone", irq_req, 4'h0);
    $display("test level %0d done", i);
  endtask

  task t_edge(input int i);
    logic [3:0] b;
    b = 4'h1 << i;
    irq_cfg = '{edge_mode: 4'hF, enable: 4'h0};
    cyc(2);
    lines_n[i] = 1'b0;
    cyc(1);
    lines_n[i] = 1'b1;
    cyc(4);
    chk("edge masked", irq_req, 4'h0);
    irq_cfg.enable = 4'hF;
    cyc(1);
    chk("edge kept", irq_req, b);
    irq_ack = b;
    cyc(1);
    chk("edge ack", irq_req, 4'h0);
    irq_ack = 4'h0;
    lines_n[i] = 1'b0;
    cyc(1);
    lines_n[i] = 1'b1;
    cyc(2);
    chk("edge early", irq_req, 4'h0);
    cyc(1);
    chk("edge req", irq_req, b);
    // Ack held across a fresh edge: the new edge must survive
    irq_ack = b;
    lines_n[i] = 1'b0;
    cyc(1);
    chk("edge ack2", irq_req, 4'h0);
    lines_n[i] = 1'b1;
    cyc(3);
    chk("set wins", irq_req, b);
    cyc(1);
    chk("ack clears", irq_req, 4'h0);
    irq_ack = 4'h0;
    $display("test edge %0d done", i);
  endtask

  // -----------------------------------------------------------------
  // Clock, timeout and main sequence
  // -----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Whole run needs well under 600 cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      give_verdict();
    end
  end

  initial
  begin
    reset = 1'b1;
    run_req = 1'b0;
    lines_n = 4'hF;
    irq_ack = 4'h0;
    irq_cfg = '{edge_mode: 4'h0, enable: 4'h0};
    core_in_wait = 1'b0;
    core_in_stop = 1'b0;
    cyc(10);
    reset = 1'b0;
    for (int m = 0; m < 16; m++)
      t_boot(m[3:0]);
    t_glitch();
    for (int i = 0; i < 4; i++)
      t_level(i);
    for (int i = 0; i < 4; i++)
      t_edge(i);
    give_verdict();
  end
endmodule // tb_reset_mode_latch_ext_irq
